// >>> qpse_pkg.sv
// Notes on behaviour
// - Product 0 plus or minus product 1 forms the first partial result.
// - Product 2 plus or minus product 3 forms the second partial result.
// - Both partial results are summed to form the element output.
// - Input, pipeline and output stages may each be bypassed.
// - Each stage picks its clock from four shared clock sources.
// - Each stage picks enable and reset from four shared sources each.
// - Unsigned overflow: new accumulator value is below the old one.
// - Signed overflow: like signs added give a total of opposite sign.
// - On overflow the accumulator wraps; the flag rises with it.
// - Overflow output is a pulse of exactly one clock per event.
// - In accumulate mode the output register is always in use.
// - Overflow indication comes from a register.
// - Add or subtract control is honoured on every clock cycle.
// - Signed or unsigned choice applies to each cycle's own operands.
package qpse_pkg;
  localparam int OP_W   = 18;
  localparam int PROD_W = 38;
  localparam int SUM_W  = 38;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK   = 4'h4;
  localparam int BIT_OVF = 0;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0;

  typedef struct packed {
    logic       reg_en;
    logic [1:0] clk_sel;
    logic [1:0] ce_sel;
    logic [1:0] rst_sel;
  } qpse_stage_cfg_type;

  typedef struct packed {
    logic op_signed;
    logic sub_01;
    logic sub_23;
  } qpse_ctl_type;

  typedef struct packed {
    logic [3:0][OP_W-1:0] a;
    logic [3:0][OP_W-1:0] b;
    qpse_ctl_type         ctl;
  } qpse_in_type;

  typedef struct packed {
    logic [3:0][PROD_W-1:0] prod;
    qpse_ctl_type           ctl;
  } qpse_pipe_type;
endpackage

// >>> qpse_quad_product_sum_element.sv
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module qpse_quad_product_sum_element (
  input  wire logic                       core_clk,        // System clock
  input  wire logic                       rst,             // Async reset
  input  wire logic [qpse_pkg::OP_W-1:0]  operand_a_pair0, // Pair 0 a
  input  wire logic [qpse_pkg::OP_W-1:0]  operand_b_pair0, // Pair 0 b
  input  wire logic [qpse_pkg::OP_W-1:0]  operand_a_pair1, // Pair 1 a
  input  wire logic [qpse_pkg::OP_W-1:0]  operand_b_pair1, // Pair 1 b
  input  wire logic [qpse_pkg::OP_W-1:0]  operand_a_pair2, // Pair 2 a
  input  wire logic [qpse_pkg::OP_W-1:0]  operand_b_pair2, // Pair 2 b
  input  wire logic [qpse_pkg::OP_W-1:0]  operand_a_pair3, // Pair 3 a
  input  wire logic [qpse_pkg::OP_W-1:0]  operand_b_pair3, // Pair 3 b
  input  wire logic                       op_signed,       // Signed operands
  input  wire logic                       sub_01,          // Subtract pair 1
  input  wire logic                       sub_23,          // Subtract pair 3
  input  wire logic                       accum_mode,      // Accumulate sum
  input  wire logic                       shared_clock_src_0, // Clock tick 0
  input  wire logic                       shared_clock_src_1, // Clock tick 1
  input  wire logic                       shared_clock_src_2, // Clock tick 2
  input  wire logic                       shared_clock_src_3, // Clock tick 3
  input  wire logic                       shared_enable_src_0, // Enable 0
  input  wire logic                       shared_enable_src_1, // Enable 1
  input  wire logic                       shared_enable_src_2, // Enable 2
  input  wire logic                       shared_enable_src_3, // Enable 3
  input  wire logic                       shared_reset_src_0, // Reset 0
  input  wire logic                       shared_reset_src_1, // Reset 1
  input  wire logic                       shared_reset_src_2, // Reset 2
  input  wire logic                       shared_reset_src_3, // Reset 3
  input  wire qpse_pkg::qpse_stage_cfg_type in_cfg,        // Input stage
  input  wire qpse_pkg::qpse_stage_cfg_type pipe_cfg,      // Pipeline stage
  input  wire qpse_pkg::qpse_stage_cfg_type out_cfg,       // Output stage
  input  wire logic [qpse_pkg::ADDR_W-1:0] reg_addr,       // Register address
  input  wire logic [qpse_pkg::DATA_W-1:0] reg_wdata,      // Write data
  input  wire logic                       reg_wr,          // Write strobe
  input  wire logic                       reg_rd,          // Read strobe
  output logic      [qpse_pkg::DATA_W-1:0] reg_rdata,      // Read data
  output logic      [qpse_pkg::SUM_W-1:0] result,          // Element output
  output logic                            overflow,        // Overflow pulse
  output logic                            irq              // Interrupt level
);

  // Four-way pick used for clocks, enables and resets
  function automatic logic pick4(input logic [3:0] v, input logic [1:0] s);
    pick4 = v[s];
  endfunction

  // Register address match, shared by the write decodes
  function automatic logic addr_hit(input logic [qpse_pkg::ADDR_W-1:0] a,
                                    input logic [qpse_pkg::ADDR_W-1:0] r);
    addr_hit = (a == r);
  endfunction

  logic [3:0] clk_v;
  logic [3:0] ce_v;
  logic [3:0] rst_v;
  assign clk_v = {shared_clock_src_3, shared_clock_src_2,
                  shared_clock_src_1, shared_clock_src_0};
  assign ce_v  = {shared_enable_src_3, shared_enable_src_2,
                  shared_enable_src_1, shared_enable_src_0};
  assign rst_v = {shared_reset_src_3, shared_reset_src_2,
                  shared_reset_src_1, shared_reset_src_0};

  // Stage ticks and stage resets, one slice per register stage
  qpse_pkg::qpse_stage_cfg_type stage_cfg [3];
  logic [2:0]                   stage_tick;
  logic [2:0]                   stage_clr;
  logic                         in_tick;
  logic                         pipe_tick;
  logic                         out_tick;
  logic                         in_clr;
  logic                         pipe_clr;
  logic                         out_clr;
  assign stage_cfg[0] = in_cfg;
  assign stage_cfg[1] = pipe_cfg;
  assign stage_cfg[2] = out_cfg;
  genvar gs;
  generate
    for (gs = 0; gs < 3; gs++) begin : g_stage_sel
      assign stage_tick[gs] = pick4(clk_v, stage_cfg[gs].clk_sel)
                            & pick4(ce_v, stage_cfg[gs].ce_sel);
      assign stage_clr[gs]  = pick4(rst_v, stage_cfg[gs].rst_sel);
    end
  endgenerate
  // Stage resets beat ticks in every next-value process below
  assign in_tick   = stage_tick[0];
  assign pipe_tick = stage_tick[1];
  assign out_tick  = stage_tick[2];
  assign in_clr    = stage_clr[0];
  assign pipe_clr  = stage_clr[1];
  assign out_clr   = stage_clr[2];

  // Input stage
  qpse_pkg::qpse_in_type in_now;
  qpse_pkg::qpse_in_type in_q;
  qpse_pkg::qpse_in_type next_in_q;
  qpse_pkg::qpse_in_type in_use;
  assign in_now.a   = {operand_a_pair3, operand_a_pair2,
                       operand_a_pair1, operand_a_pair0};
  assign in_now.b   = {operand_b_pair3, operand_b_pair2,
                       operand_b_pair1, operand_b_pair0};
  assign in_now.ctl = '{op_signed: op_signed, sub_01: sub_01,
                        sub_23: sub_23};

  always_comb begin
    next_in_q = in_q;
    if (in_clr) begin
      next_in_q = '0;
    end else if (in_tick) begin
      next_in_q = in_now;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_q <= '0;
    end else begin
      in_q <= next_in_q;
    end
  end

  assign in_use = in_cfg.reg_en ? in_q : in_now;

  // Four multipliers, signedness per operand set
  qpse_pkg::qpse_pipe_type prod_now;
  qpse_pkg::qpse_pipe_type pipe_q;
  qpse_pkg::qpse_pipe_type next_pipe_q;
  qpse_pkg::qpse_pipe_type pipe_use;
  assign prod_now.ctl = in_use.ctl;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mult
      logic signed [qpse_pkg::OP_W:0] ea;
      logic signed [qpse_pkg::OP_W:0] eb;
      assign ea = {in_use.ctl.op_signed & in_use.a[gi][qpse_pkg::OP_W-1],
                   in_use.a[gi]};
      assign eb = {in_use.ctl.op_signed & in_use.b[gi][qpse_pkg::OP_W-1],
                   in_use.b[gi]};
      assign prod_now.prod[gi] = ea * eb;
    end
  endgenerate

  // Pipeline stage
  always_comb begin
    next_pipe_q = pipe_q;
    if (pipe_clr) begin
      next_pipe_q = '0;
    end else if (pipe_tick) begin
      next_pipe_q = prod_now;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= next_pipe_q;
    end
  end

  assign pipe_use = pipe_cfg.reg_en ? pipe_q : prod_now;

  // Add/subtract pairs and summation
  logic [qpse_pkg::SUM_W-1:0] part_01;
  logic [qpse_pkg::SUM_W-1:0] part_23;
  logic [qpse_pkg::SUM_W-1:0] sum_now;
  assign part_01 = pipe_use.ctl.sub_01
                 ? pipe_use.prod[0] - pipe_use.prod[1]
                 : pipe_use.prod[0] + pipe_use.prod[1];
  assign part_23 = pipe_use.ctl.sub_23
                 ? pipe_use.prod[2] - pipe_use.prod[3]
                 : pipe_use.prod[2] + pipe_use.prod[3];
  assign sum_now = part_01 + part_23;

  // Output stage with accumulator and overflow
  logic [qpse_pkg::SUM_W-1:0] out_q;
  logic [qpse_pkg::SUM_W-1:0] next_out_q;
  logic [qpse_pkg::SUM_W-1:0] acc_sum;
  logic                       ovf_q;
  logic                       next_ovf_q;
  logic                       ovf_event;
  logic                       old_s;
  logic                       add_s;
  logic                       new_s;
  assign acc_sum = out_q + sum_now;
  assign old_s   = out_q[qpse_pkg::SUM_W-1];
  assign add_s   = sum_now[qpse_pkg::SUM_W-1];
  assign new_s   = acc_sum[qpse_pkg::SUM_W-1];

  always_comb begin
    ovf_event = 1'b0;
    if (pipe_use.ctl.op_signed) begin
      ovf_event = (old_s == add_s) && (new_s != old_s);
    end else begin
      ovf_event = acc_sum < out_q;
    end
  end

  always_comb begin
    next_out_q = out_q;
    next_ovf_q = 1'b0;
    if (out_clr) begin
      next_out_q = '0;
    end else if (out_tick) begin
      if (accum_mode) begin
        next_out_q = acc_sum;
        next_ovf_q = ovf_event;
      end else begin
        next_out_q = sum_now;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      out_q <= next_out_q;
      ovf_q <= next_ovf_q;
    end
  end

  assign result   = (out_cfg.reg_en | accum_mode) ? out_q : sum_now;
  assign overflow = ovf_q;

  // Status, mask and read port
  logic [qpse_pkg::DATA_W-1:0] status_q;
  logic [qpse_pkg::DATA_W-1:0] mask_q;
  logic [qpse_pkg::DATA_W-1:0] rdata_q;
  logic [qpse_pkg::DATA_W-1:0] next_status;
  logic [qpse_pkg::DATA_W-1:0] next_mask;
  logic [qpse_pkg::DATA_W-1:0] next_rdata;
  logic                        irq_q;
  logic                        next_irq;
  logic                        wr_status;
  logic                        wr_mask;

  // Write decodes
  assign wr_status = reg_wr & addr_hit(reg_addr, qpse_pkg::REG_STATUS);
  assign wr_mask   = reg_wr & addr_hit(reg_addr, qpse_pkg::REG_MASK);

  always_comb begin
    next_status = status_q;
    next_mask   = mask_q;
    next_rdata  = '0;
    if (wr_status) begin
      next_status = status_q & ~reg_wdata;
    end
    if (wr_mask) begin
      next_mask = reg_wdata & 32'h1;
    end
    // Set wins over a same-cycle clear
    if (ovf_q) begin
      next_status[qpse_pkg::BIT_OVF] = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        qpse_pkg::REG_STATUS: next_rdata = status_q;
        qpse_pkg::REG_MASK:   next_rdata = mask_q;
        default:              next_rdata = '0;
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_q <= qpse_pkg::RESET_WORD;
      mask_q   <= qpse_pkg::RESET_WORD;
      rdata_q  <= qpse_pkg::RESET_WORD;
      irq_q    <= 1'b0;
    end else begin
      status_q <= next_status;
      mask_q   <= next_mask;
      rdata_q  <= next_rdata;
      irq_q    <= next_irq;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = irq_q;

endmodule // qpse_quad_product_sum_element

// >>> qpse_fabric_model.sv
`timescale 1ns/1ps
// Fabric logic that pads operands before the element
module qpse_fabric_model (
  input  wire logic [7:0][17:0] raw,       // Operand sources
  input  wire logic             narrow,    // Only low 9 bits valid
  input  wire logic             op_signed, // Two's complement
  output logic      [7:0][17:0] ops        // Padded operands
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ops[i] = raw[i];
      if (narrow) ops[i][17:9] = {9{op_signed & raw[i][8]}};
    end
  end
endmodule // qpse_fabric_model

// >>> qpse_chk.sv
`timescale 1ns/1ps
// Port checks on the product sum element
module qpse_chk (
  input wire logic                         core_clk,   // Clock
  input wire logic                         rst,        // Reset
  input wire logic [qpse_pkg::ADDR_W-1:0]  reg_addr,   // Address
  input wire logic                         reg_wr,     // Write
  input wire logic                         reg_rd,     // Read
  input wire logic [qpse_pkg::DATA_W-1:0]  reg_rdata,  // Read data
  input wire logic [qpse_pkg::SUM_W-1:0]   result,     // Output
  input wire logic                         overflow,   // Pulse
  input wire logic                         irq,        // Interrupt
  input wire logic                         accum_mode, // Accumulate
  input wire qpse_pkg::qpse_stage_cfg_type out_cfg,    // Output stage
  input wire logic                         shared_clock_src_0, // Tick
  input wire logic                         shared_clock_src_1, // Tick
  input wire logic                         shared_clock_src_2, // Tick
  input wire logic                         shared_clock_src_3, // Tick
  input wire logic                         shared_enable_src_0, // Enable
  input wire logic                         shared_enable_src_1, // Enable
  input wire logic                         shared_enable_src_2, // Enable
  input wire logic                         shared_enable_src_3, // Enable
  input wire logic                         shared_reset_src_0, // Reset
  input wire logic                         shared_reset_src_1, // Reset
  input wire logic                         shared_reset_src_2, // Reset
  input wire logic                         shared_reset_src_3  // Reset
);
  logic [3:0] ck;
  logic [3:0] rs;
  logic [3:0] ce;
  logic       tick_o;
  logic       clr_o;
  logic       out_reg;
  // Output stage selections
  assign ck = {shared_clock_src_3, shared_clock_src_2, shared_clock_src_1,
               shared_clock_src_0};
  assign rs = {shared_reset_src_3, shared_reset_src_2, shared_reset_src_1,
               shared_reset_src_0};
  assign ce = {shared_enable_src_3, shared_enable_src_2, shared_enable_src_1,
               shared_enable_src_0};
  assign tick_o = ck[out_cfg.clk_sel] & ce[out_cfg.ce_sel];
  assign clr_o = rs[out_cfg.rst_sel];
  assign out_reg = out_cfg.reg_en | accum_mode;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read slot");
  a_unmapped_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) != qpse_pkg::REG_STATUS &&
    $past(reg_addr) != qpse_pkg::REG_MASK |-> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_upper_bits_zero: assert property ($past(reg_rd) |-> reg_rdata[31:1] == '0)
    else $error("unused register bits set");
  a_irq_rise_cause: assert property ($rose(irq) |->
    overflow || $past(overflow) || $past(reg_wr))
    else $error("interrupt rose without cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("interrupt fell without write");
  a_ovf_from_accum: assert property (overflow |->
    $past(accum_mode) && $past(tick_o) && !$past(clr_o))
    else $error("overflow without accumulate load");
  a_stage_clear: assert property (out_reg && clr_o |=>
    !overflow && (!out_reg || result == '0))
    else $error("stage reset did not clear");
  a_hold_no_tick: assert property (out_reg && !tick_o && !clr_o |=>
    !out_reg || ($stable(result) && !overflow))
    else $error("output changed without tick");
  c_overflow: cover property (overflow);
  c_irq: cover property ($rose(irq));
  c_clear: cover property (out_reg && clr_o);
endmodule // qpse_chk
bind qpse_quad_product_sum_element qpse_chk u_qpse_chk (.*);

// >>> qpse_quad_product_sum_element_tb.sv
`timescale 1ns/1ps
// Bench for the product sum element
module qpse_quad_product_sum_element_tb;
  logic core_clk, rst, narrow, op_signed, sub_01, sub_23, accum_mode, ov;
  logic [17:0] operand_a_pair0, operand_b_pair0, operand_a_pair1;
  logic [17:0] operand_b_pair1, operand_a_pair2, operand_b_pair2;
  logic [17:0] operand_a_pair3, operand_b_pair3;
  logic [7:0][17:0] raw, ops;
  logic [3:0] clk_src, ce_src, rst_src;
  logic shared_clock_src_0, shared_clock_src_1, shared_clock_src_2;
  logic shared_clock_src_3, shared_enable_src_0, shared_enable_src_1;
  logic shared_enable_src_2, shared_enable_src_3, shared_reset_src_0;
  logic shared_reset_src_1, shared_reset_src_2, shared_reset_src_3;
  qpse_pkg::qpse_stage_cfg_type in_cfg, pipe_cfg, out_cfg;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, overflow, irq;
  logic [37:0] result, acc, e, s;
  logic [37:0] hist [16];
  int miscompares, num_checks;
  // Fan out operand and source vectors
  assign {operand_b_pair3, operand_a_pair3, operand_b_pair2, operand_a_pair2,
          operand_b_pair1, operand_a_pair1, operand_b_pair0,
          operand_a_pair0} = ops;
  assign {shared_clock_src_3, shared_clock_src_2, shared_clock_src_1,
          shared_clock_src_0} = clk_src;
  assign {shared_enable_src_3, shared_enable_src_2, shared_enable_src_1,
          shared_enable_src_0} = ce_src;
  assign {shared_reset_src_3, shared_reset_src_2, shared_reset_src_1,
          shared_reset_src_0} = rst_src;
  qpse_quad_product_sum_element u_qpse_quad_product_sum_element (.*);
  qpse_fabric_model u_qpse_fabric_model (.*);
  // Expected sum of the four products
  function automatic logic [37:0] qsum(input logic [2:0] f);
    logic [37:0] p [4];
    for (int i = 0; i < 4; i++)
      p[i] = {{20{f[2] & ops[2*i][17]}}, ops[2*i]} *
             {{20{f[2] & ops[2*i+1][17]}}, ops[2*i+1]};
    return (f[1] ? p[0] - p[1] : p[0] + p[1]) +
           (f[0] ? p[2] - p[3] : p[2] + p[3]);
  endfunction
  task chk(input logic [37:0] got, input logic [37:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] x);
    @(posedge core_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, x);
  endtask
  task stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end
  // Main sequence
  initial begin
    {rst, narrow, op_signed, sub_01, sub_23, accum_mode} = 6'h20;
    {reg_wr, reg_rd, reg_addr, reg_wdata, raw} = '0;
    {in_cfg, pipe_cfg, out_cfg} = '0;
    {clk_src, ce_src, rst_src} = 12'hff0;
    {miscompares, num_checks} = '0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(qpse_pkg::REG_STATUS, 32'h0);
    rd(qpse_pkg::REG_MASK, 32'h0);
    // All stages bypassed, narrow operands, every mode
    for (int m = 0; m < 8; m++) begin
      @(posedge core_clk);
      {narrow, op_signed, sub_01, sub_23} <= {1'b1, 3'(m)};
      for (int i = 0; i < 8; i++) raw[i] <= 18'h2a1fa + 18'(37 * i + m);
      #1 chk(result, qsum({op_signed, sub_01, sub_23}));
    end
    // All stages registered, new operands and modes every cycle
    for (int k = 0; k < 12; k++) begin
      @(posedge core_clk);
      {in_cfg.reg_en, pipe_cfg.reg_en, out_cfg.reg_en, narrow} <= 4'he;
      {op_signed, sub_01, sub_23} <= 3'(k);
      for (int i = 0; i < 8; i++) raw[i] <= 18'h3ffff - 18'(4099 * (i + k));
      #1 hist[k] = qsum({op_signed, sub_01, sub_23});
      if (k >= 3) chk(result, hist[k - 3]);
    end
    step(3);
    // Output tick gated, then output enable gated
    for (int j = 0; j < 2; j++) begin
      @(posedge core_clk);
      out_cfg.clk_sel <= j ? 2'h0 : 2'h2;
      out_cfg.ce_sel <= j ? 2'h3 : 2'h0;
      {clk_src, ce_src} <= j ? 8'hf7 : 8'hbf;
      raw <= ~raw;
      #1 e = qsum({op_signed, sub_01, sub_23});
      step(5);
      chk(result, hist[11]);
      @(posedge core_clk);
      {clk_src, ce_src} <= 8'hff;
      step(1);
      chk(result, e);
      hist[11] = e;
    end
    // Input and pipeline stage resets, output stage left running
    @(posedge core_clk);
    {in_cfg.rst_sel, pipe_cfg.rst_sel, rst_src} <= {4'ha, 4'h4};
    @(posedge core_clk);
    rst_src <= 4'h0;
    step(1);
    chk(result, 38'h0);
    step(2);
    chk(result, e);
    // Stage reset, then unsigned and signed accumulation
    for (int sg = 0; sg < 2; sg++) begin
      @(posedge core_clk);
      {in_cfg.reg_en, pipe_cfg.reg_en, out_cfg.reg_en} <= 3'h0;
      {out_cfg.rst_sel, rst_src, accum_mode} <= {2'h1, 4'h2, 1'b1};
      {op_signed, sub_01, sub_23} <= {sg[0], 2'h0};
      raw <= {8{sg ? 18'h20000 : 18'h3ffff}};
      @(posedge core_clk);
      rst_src <= 4'h0;
      #1 chk(result, 38'h0);
      chk(overflow, 1'b0);
      acc = '0;
      for (int c = 0; c < 3; c++) begin
        s = qsum({op_signed, sub_01, sub_23});
        e = acc + s;
        ov = sg ? (acc[37] == s[37] && e[37] != acc[37]) : (e < acc);
        step(1);
        chk(result, e);
        chk(overflow, ov);
        acc = e;
      end
    end
    // Sticky status, mask, clear and unmapped access
    @(posedge core_clk);
    accum_mode <= 1'b0;
    rd(qpse_pkg::REG_STATUS, 32'h1);
    chk(irq, 1'b0);
    wr(qpse_pkg::REG_MASK, 32'hffffffff);
    #1 chk(irq, 1'b1);
    rd(qpse_pkg::REG_MASK, 32'h1);
    wr(qpse_pkg::REG_STATUS, 32'h1);
    #1 chk(irq, 1'b0);
    rd(qpse_pkg::REG_STATUS, 32'h0);
    rd(4'h8, 32'h0);
    stop_test();
  end
endmodule // qpse_quad_product_sum_element_tb
